/* hw/pic_port_irq_ctrl.sv */
// Port interrupt control: edge detection, pending flags, enables and drive select for three ports.
// Assumes pins arrive asynchronously, the resume event comes from logic on mclk, and an AXI4-Lite master.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module pic_port_irq_ctrl
  import pic_pkg::*;
#(
  parameter bit USB_VARIANT = 1'b0                      // Build the resume-event variant of line 7.
) (
  input  wire logic                    mclk,              // System clock, 250 MHz.
  input  wire logic                    reset_n,           // Synchronous reset, active low.
  input  wire logic [PIC_FIRST_W-1:0]  first_port_pins,   // First port input levels.
  input  wire logic [PIC_SECOND_W-1:0] second_port_pins,  // Second port input levels.
  input  wire logic [PIC_THIRD_W-1:0]  third_port_pins,   // Third port input levels.
  input  wire logic                    usb_resume,        // Resume level from the USB logic, on mclk.
  output logic                         output_drive_select, // Drive strength for output pins.
  output logic [PIC_IRQ_W-1:0]         port_irq_req,      // Per-port request to the CPU.
  output logic                         irq_out,           // Masked event interrupt.
  input  wire logic [PIC_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [PIC_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // State of the whole block.
  typedef struct packed {
    logic [PIC_PINS_W-1:0]   sync1;        // First synchroniser stage, read only by the second.
    logic [PIC_PINS_W-1:0]   sync2;        // Second synchroniser stage.
    logic [PIC_PINS_W-1:0]   sync3;        // Third synchroniser stage.
    logic [PIC_PINS_W-1:0]   filt;         // Accepted level, moves when stages two and three agree.
    logic                    usb_prev;     // Previous resume level for its rising edge.
    logic [PIC_FIRST_W-1:0]  flags0;       // First port pending flags.
    logic [PIC_SECOND_W-1:0] flags1;       // Second port pending flags.
    logic [PIC_THIRD_W-1:0]  flags2;       // Third port pending flags.
    logic [PIC_CTL_W-1:0]    ctrl;         // Control register, bit 7 is not stored.
    logic [PIC_SECOND_W-1:0] mask1;        // Second port per-pin mask.
    logic [PIC_IRQ_W-1:0]    irq_stat;     // Sticky event status.
    logic [PIC_IRQ_W-1:0]    irq_mask;     // Event mask.
    logic [PIC_IRQ_W-1:0]    port_irq;     // Registered per-port requests.
    logic                    irq;          // Registered interrupt output.
    logic                    aw_full;      // Write address held.
    logic [PIC_ADDR_W-1:0]   aw_addr;
    logic                    w_full;       // Write data held.
    logic [7:0]              w_data;
    logic                    w_lane0;      // Byte lane 0 was strobed.
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } pic_state_s;

  pic_state_s state_reg;   // Registered state.
  pic_state_s state_next;  // Next state from the combinational process.

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Edge detector shared by all ports; falling selects the falling edge.
  function automatic logic [7:0] pic_edge_hit(input logic [7:0] prev, input logic [7:0] now,
                                              input logic falling);
    pic_edge_hit = falling ? (prev & ~now) : (~prev & now);
  endfunction : pic_edge_hit

  // Enable vector of the first port from the control bits.
  function automatic logic [7:0] pic_first_en(input logic [PIC_CTL_W-1:0] ctl);
    pic_first_en = {{4{ctl[PIC_CTL_FIRST_HI_EN]}}, {4{ctl[PIC_CTL_FIRST_LO_EN]}}};
  endfunction : pic_first_en

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Next-state logic: synchronisers, edges, flags, register writes and reads, bus handshakes.
  always_comb begin
    logic [PIC_PINS_W-1:0] agree;  // Stages two and three hold the same level.
    logic [7:0]            hit0;   // First port edges this cycle.
    logic [7:0]            hit1;   // Second port edges this cycle.
    logic [7:0]            hit2w;  // Third port edges, zero extended.
    logic [PIC_THIRD_W-1:0] hit2;
    logic [7:0]            clr0;   // Flags cleared by a write of zero.
    logic [7:0]            clr1;
    logic [PIC_THIRD_W-1:0] clr2;
    logic [PIC_IRQ_W-1:0]  w1c;    // Status bits cleared by a write of one.
    logic [PIC_IRQ_W-1:0]  ev;     // Enabled edges this cycle.
    logic                  do_write;
    logic                  usb_rise;
    agree    = '0;
    hit0     = '0;
    hit1     = '0;
    hit2w    = '0;
    hit2     = '0;
    clr0     = '0;
    clr1     = '0;
    clr2     = '0;
    w1c      = '0;
    ev       = '0;
    do_write = 1'b0;
    usb_rise = 1'b0;
    state_next = state_reg;

    // Three-stage synchroniser; a change counts only once stages two and three agree,
    // so a pin must hold a new level for two cycles to be seen at all.
    state_next.sync1 = {third_port_pins, second_port_pins, first_port_pins};
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    agree            = ~(state_reg.sync2 ^ state_reg.sync3);
    state_next.filt  = (state_reg.filt & ~agree) | (state_reg.sync3 & agree);

    // Edge detection on the accepted level, with one edge select per port.
    hit0  = pic_edge_hit(state_reg.filt[7:0], state_next.filt[7:0],
                         state_reg.ctrl[PIC_CTL_FIRST_EDGE]);
    hit1  = pic_edge_hit(state_reg.filt[15:8], state_next.filt[15:8],
                         state_reg.ctrl[PIC_CTL_SECOND_EDGE]);
    hit2w = pic_edge_hit({3'h0, state_reg.filt[20:16]}, {3'h0, state_next.filt[20:16]},
                         state_reg.ctrl[PIC_CTL_THIRD_EDGE]);
    hit2  = hit2w[PIC_THIRD_W-1:0];

    // The resume event takes the place of line 7 and is always a rising edge, which is why
    // software must leave the first port on rising edges while USB is in use.
    state_next.usb_prev = usb_resume;
    usb_rise            = usb_resume & ~state_reg.usb_prev;
    if (USB_VARIANT) begin
      hit0[PIC_USB_LINE]    = usb_rise;
      hit0[PIC_UNUSED_LINE] = 1'b0;
    end

    // Register writes, once address and data are both held and no answer is pending.
    do_write = state_reg.aw_full & state_reg.w_full & ~state_reg.bvalid;
    if (do_write) begin
      state_next.aw_full = 1'b0;
      state_next.w_full  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = pic_is_mapped(state_reg.aw_addr) ? PIC_RESP_OKAY : PIC_RESP_SLVERR;
      if (state_reg.w_lane0) begin
        case (state_reg.aw_addr)
          PIC_OFS_FIRST_FLAGS: begin
            clr0 = ~state_reg.w_data;
          end
          PIC_OFS_SECOND_FLAGS: begin
            clr1 = ~state_reg.w_data;
          end
          PIC_OFS_THIRD_FLAGS: begin
            clr2 = ~state_reg.w_data[PIC_THIRD_W-1:0];
          end
          PIC_OFS_CONTROL: begin
            state_next.ctrl = state_reg.w_data[PIC_CTL_W-1:0];
          end
          PIC_OFS_SECOND_MASK: begin
            state_next.mask1 = state_reg.w_data;
          end
          PIC_OFS_IRQ_STATUS: begin
            w1c = state_reg.w_data[PIC_IRQ_W-1:0];
          end
          PIC_OFS_IRQ_MASK: begin
            state_next.irq_mask = state_reg.w_data[PIC_IRQ_W-1:0];
          end
          default: begin
            // Unmapped address: nothing is stored, the answer carries an error.
          end
        endcase
      end
    end

    // Pending flags: a new edge wins over a clear in the same cycle.
    state_next.flags0 = (state_reg.flags0 & ~clr0) | hit0;
    state_next.flags1 = (state_reg.flags1 & ~clr1) | hit1;
    state_next.flags2 = (state_reg.flags2 & ~clr2) | hit2;

    // Sticky events: an edge on an enabled line of a port; set wins over clear.
    ev[PIC_IRQ_FIRST]   = |(hit0 & pic_first_en(state_reg.ctrl));
    ev[PIC_IRQ_SECOND]  = |(hit1 & state_reg.mask1);
    ev[PIC_IRQ_THIRD]   = (|hit2) & state_reg.ctrl[PIC_CTL_THIRD_EN];
    state_next.irq_stat = (state_reg.irq_stat & ~w1c) | ev;

    // Per-port requests stand while an enabled flag is pending.
    state_next.port_irq[PIC_IRQ_FIRST]  = |(state_next.flags0 & pic_first_en(state_next.ctrl));
    state_next.port_irq[PIC_IRQ_SECOND] = |(state_next.flags1 & state_next.mask1);
    state_next.port_irq[PIC_IRQ_THIRD]  = (|state_next.flags2) &
                                          state_next.ctrl[PIC_CTL_THIRD_EN];
    state_next.irq = |(state_next.irq_stat & state_next.irq_mask);

    // Write channels are taken in either order and held until the write is done.
    if (s_axi_awvalid && !state_reg.aw_full) begin
      state_next.aw_full = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_full) begin
      state_next.w_full  = 1'b1;
      state_next.w_data  = s_axi_wdata[7:0];
      state_next.w_lane0 = s_axi_wstrb[0];
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken; upper bits read as zero.
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !state_reg.rvalid) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = pic_is_mapped(s_axi_araddr) ? PIC_RESP_OKAY : PIC_RESP_SLVERR;
      case (s_axi_araddr)
        PIC_OFS_FIRST_FLAGS: begin
          state_next.rdata = {24'h0, state_reg.flags0};
        end
        PIC_OFS_SECOND_FLAGS: begin
          state_next.rdata = {24'h0, state_reg.flags1};
        end
        PIC_OFS_THIRD_FLAGS: begin
          state_next.rdata = {27'h0, state_reg.flags2};
        end
        PIC_OFS_CONTROL: begin
          state_next.rdata = {25'h0, state_reg.ctrl};
        end
        PIC_OFS_SECOND_MASK: begin
          state_next.rdata = {24'h0, state_reg.mask1};
        end
        PIC_OFS_IRQ_STATUS: begin
          state_next.rdata = {29'h0, state_reg.irq_stat};
        end
        PIC_OFS_IRQ_MASK: begin
          state_next.rdata = {29'h0, state_reg.irq_mask};
        end
        default: begin
          state_next.rdata = 32'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_reg          <= '0;
      state_reg.ctrl     <= PIC_CONTROL_RESET;
      state_reg.flags0   <= PIC_FLAGS8_RESET;
      state_reg.flags1   <= PIC_FLAGS8_RESET;
      state_reg.flags2   <= PIC_FLAGS5_RESET;
      state_reg.mask1    <= PIC_MASK_RESET;
      state_reg.irq_stat <= PIC_IRQ_RESET;
      state_reg.irq_mask <= PIC_IRQ_RESET;
      state_reg.bresp    <= PIC_RESP_OKAY;
      state_reg.rresp    <= PIC_RESP_OKAY;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs. Ready signals are combinational so that a held channel stalls the master at once.
  assign output_drive_select = state_reg.ctrl[PIC_CTL_DRIVE];
  assign port_irq_req        = state_reg.port_irq;
  assign irq_out             = state_reg.irq;
  assign s_axi_awready       = ~state_reg.aw_full;
  assign s_axi_wready        = ~state_reg.w_full;
  assign s_axi_bvalid        = state_reg.bvalid;
  assign s_axi_bresp         = state_reg.bresp;
  assign s_axi_arready       = ~state_reg.rvalid;
  assign s_axi_rvalid        = state_reg.rvalid;
  assign s_axi_rdata         = state_reg.rdata;
  assign s_axi_rresp         = state_reg.rresp;

endmodule : pic_port_irq_ctrl

/* include/pic_pkg.sv */
// Shared constants for the port interrupt control block: register map, field positions and reset values.
// Assumes a 32-bit AXI4-Lite master with byte addressing and the 250 MHz system clock.
package pic_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int unsigned PIC_ADDR_W   = 8;   // Byte address width of the register bus.
  localparam int unsigned PIC_FIRST_W  = 8;   // Lines of the first port.
  localparam int unsigned PIC_SECOND_W = 8;   // Lines of the second port.
  localparam int unsigned PIC_THIRD_W  = 5;   // Lines of the third port.
  localparam int unsigned PIC_PINS_W   = 21;  // All synchronised lines, third port on top.
  localparam int unsigned PIC_CTL_W    = 7;   // Stored bits of the control register.
  localparam int unsigned PIC_IRQ_W    = 3;   // One sticky event bit per port.

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets, one aligned word each.
  localparam logic [7:0] PIC_OFS_FIRST_FLAGS  = 8'h80;  // First port pending flags.
  localparam logic [7:0] PIC_OFS_SECOND_FLAGS = 8'h84;  // Second port pending flags.
  localparam logic [7:0] PIC_OFS_THIRD_FLAGS  = 8'h88;  // Third port pending flags.
  localparam logic [7:0] PIC_OFS_CONTROL      = 8'h8c;  // Port interrupt control.
  localparam logic [7:0] PIC_OFS_SECOND_MASK  = 8'h90;  // Second port per-pin mask.
  localparam logic [7:0] PIC_OFS_IRQ_STATUS   = 8'h94;  // Sticky event status, write one to clear.
  localparam logic [7:0] PIC_OFS_IRQ_MASK     = 8'h98;  // Event mask onto the interrupt output.

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Control register field positions.
  localparam int unsigned PIC_CTL_FIRST_EDGE   = 0;  // First port edge select, 1 means falling.
  localparam int unsigned PIC_CTL_SECOND_EDGE  = 1;  // Second port edge select, 1 means falling.
  localparam int unsigned PIC_CTL_THIRD_EDGE   = 2;  // Third port edge select, 1 means falling.
  localparam int unsigned PIC_CTL_FIRST_LO_EN  = 3;  // First port lines 3..0 enable.
  localparam int unsigned PIC_CTL_FIRST_HI_EN  = 4;  // First port lines 7..4 enable.
  localparam int unsigned PIC_CTL_THIRD_EN     = 5;  // Third port enable.
  localparam int unsigned PIC_CTL_DRIVE        = 6;  // Output drive select, 1 means maximum.

  // Event status bit positions.
  localparam int unsigned PIC_IRQ_FIRST  = 0;
  localparam int unsigned PIC_IRQ_SECOND = 1;
  localparam int unsigned PIC_IRQ_THIRD  = 2;

  // Line positions used by the USB-capable variant.
  localparam int unsigned PIC_USB_LINE    = 7;  // Resume event replaces this first port line.
  localparam int unsigned PIC_UNUSED_LINE = 6;  // Flag that is never set in that variant.

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [6:0] PIC_CONTROL_RESET = 7'h00;
  localparam logic [7:0] PIC_FLAGS8_RESET  = 8'h00;
  localparam logic [4:0] PIC_FLAGS5_RESET  = 5'h00;
  localparam logic [7:0] PIC_MASK_RESET    = 8'h00;
  localparam logic [2:0] PIC_IRQ_RESET     = 3'h0;

  // Bus response codes.
  localparam logic [1:0] PIC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PIC_RESP_SLVERR = 2'h2;

  // True when the byte address hits one of the registers.
  function automatic logic pic_is_mapped(input logic [7:0] addr);
    pic_is_mapped = (addr == PIC_OFS_FIRST_FLAGS) || (addr == PIC_OFS_SECOND_FLAGS) ||
                    (addr == PIC_OFS_THIRD_FLAGS) || (addr == PIC_OFS_CONTROL) ||
                    (addr == PIC_OFS_SECOND_MASK) || (addr == PIC_OFS_IRQ_STATUS) ||
                    (addr == PIC_OFS_IRQ_MASK);
  endfunction : pic_is_mapped

endpackage : pic_pkg

/* verification/pic_pin_model.sv */
// Model of the outside world on the port pins: push-pull sources that follow the bench's wishes.
// Assumes the bench asks for new levels on mclk edges; the pins then move out of phase with mclk.
`timescale 1ns/1ps

module pic_pin_model
  import pic_pkg::*;
(
  input  wire logic [PIC_PINS_W-1:0]   want_levels,      // Requested levels, third port on top.
  output logic      [PIC_FIRST_W-1:0]  first_port_pins,  // First port lines.
  output logic      [PIC_SECOND_W-1:0] second_port_pins, // Second port lines.
  output logic      [PIC_THIRD_W-1:0]  third_port_pins   // Third port lines.
);
  initial {third_port_pins, second_port_pins, first_port_pins} = '0;
  // A skew of a fraction of a cycle keeps the pin changes asynchronous, as real pins are.
  always @(want_levels) begin
    #1.3 {third_port_pins, second_port_pins, first_port_pins} = want_levels;
  end
endmodule : pic_pin_model

/* verification/pic_port_irq_ctrl_asserts.sv */
// Checker for the port interrupt control block: bus answers, held outputs and the causes of output changes.
// Assumes it is bound into pic_port_irq_ctrl and sees nothing but that module's ports.
`timescale 1ns/1ps

module pic_port_irq_ctrl_asserts
  import pic_pkg::*;
(
  input wire logic               mclk,                // System clock.
  input wire logic               reset_n,             // Synchronous reset, active low.
  input wire logic               output_drive_select, // Drive strength output.
  input wire logic [PIC_IRQ_W-1:0] port_irq_req,      // Per-port requests.
  input wire logic               irq_out,             // Masked event interrupt.
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic [PIC_ADDR_W-1:0] s_axi_araddr,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // The read address is only valid until it is taken, so it is kept here for checking the answer.
  logic [7:0] rd_addr_reg;  // Address of the read under way.
  logic       mapped;       // The kept address hits a register.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_addr_reg <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_reg <= s_axi_araddr;
    end
  end
  assign mapped = (rd_addr_reg[1:0] == 2'h0) && (rd_addr_reg >= 8'h80) && (rd_addr_reg <= 8'h98);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Bus answers and held outputs.
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_unmapped_err: assert property (s_axi_rvalid && !mapped |-> s_axi_rresp == PIC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Register contents and outputs.
  a_ctl_top_zero: assert property (s_axi_rvalid && rd_addr_reg == PIC_OFS_CONTROL |-> s_axi_rdata[31:7] == 25'h0)
    else $error("control top bits not zero");
  a_drive_by_write: assert property ($changed(output_drive_select) |-> $rose(s_axi_bvalid))
    else $error("drive select moved without write");
  a_req_fall_write: assert property (|($past(port_irq_req) & ~port_irq_req) |-> $rose(s_axi_bvalid))
    else $error("request dropped without write");
  a_irq_fall_write: assert property ($fell(irq_out) |-> $rose(s_axi_bvalid))
    else $error("interrupt dropped without write");

endmodule : pic_port_irq_ctrl_asserts

bind pic_port_irq_ctrl pic_port_irq_ctrl_asserts u_pic_port_irq_ctrl_asserts (.mclk, .reset_n,
  .output_drive_select, .port_irq_req, .irq_out, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

/* verification/pic_port_irq_ctrl_tb.sv */
// Self-checking bench for the port interrupt control block, with a behavioural model of its registers.
// Assumes the pin model on the port pins and an AXI4-Lite master written here.
`timescale 1ns/1ps

module pic_port_irq_ctrl_tb;
  import pic_pkg::*;
  logic mclk = 0, reset_n = 0, usb_resume = 0;  // No USB in use, any edge select legal.
  logic [PIC_PINS_W-1:0] want = '0, m_lvl = '0;  // Requested pins and the model's view of them.
  logic [7:0] first_port_pins, second_port_pins, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [4:0] third_port_pins;
  logic output_drive_select, irq_out, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [2:0] port_irq_req, m_stat = 0, m_imask = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] m_ctl = 0, m_f0 = 0, m_f1 = 0, m_mask2 = 0;  // Model registers.
  logic [4:0] m_f2 = 0;
  logic [31:0] rd;
  int fail_count = 0, total_checks = 0;

  always #2 mclk = ~mclk;
  pic_port_irq_ctrl u_pic_port_irq_ctrl (.mclk, .reset_n, .first_port_pins, .second_port_pins, .third_port_pins,
    .usb_resume, .output_drive_select, .port_irq_req, .irq_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pic_pin_model u_pic_pin_model (.want_levels(want), .first_port_pins, .second_port_pins, .third_port_pins);

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Bus master: samples at each rising edge, before the registers move, and releases there.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge mclk); if (s_axi_awready) s_axi_awvalid <= 0; if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge mclk); while (!s_axi_bvalid);
    r = s_axi_bresp; s_axi_bready <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge mclk); if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
  endtask : axi_rd

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Model side: expected outputs, register writes and pin steps.
  task automatic check_outs();
    logic [2:0] er;
    er[0] = |(m_f0 & {{4{m_ctl[4]}}, {4{m_ctl[3]}}});
    er[1] = |(m_f1 & m_mask2);
    er[2] = (|m_f2) & m_ctl[5];
    check("port_irq_req", {29'h0, er}, {29'h0, port_irq_req});
    check("irq_out", {31'h0, |(m_stat & m_imask)}, {31'h0, irq_out});
    check("output_drive_select", {31'h0, m_ctl[6]}, {31'h0, output_drive_select});
  endtask : check_outs
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, resp);
    check("bresp", {30'h0, PIC_RESP_OKAY}, {30'h0, resp});
    case (a)
      PIC_OFS_CONTROL:      m_ctl = d[7:0] & 8'h7f;
      PIC_OFS_FIRST_FLAGS:  m_f0 &= d[7:0];
      PIC_OFS_SECOND_FLAGS: m_f1 &= d[7:0];
      PIC_OFS_THIRD_FLAGS:  m_f2 &= d[4:0];
      PIC_OFS_SECOND_MASK:  m_mask2 = d[7:0];
      PIC_OFS_IRQ_STATUS:   m_stat &= ~d[2:0];
      default:              m_imask = d[2:0];
    endcase
    check_outs();
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, rd, resp);
    check("read data", e, rd);
    check("rresp", {30'h0, PIC_RESP_OKAY}, {30'h0, resp});
  endtask : reg_rd
  task automatic read_all();
    reg_rd(PIC_OFS_FIRST_FLAGS, {24'h0, m_f0});
    reg_rd(PIC_OFS_SECOND_FLAGS, {24'h0, m_f1});
    reg_rd(PIC_OFS_THIRD_FLAGS, {27'h0, m_f2});
    reg_rd(PIC_OFS_CONTROL, {24'h0, m_ctl});
    reg_rd(PIC_OFS_SECOND_MASK, {24'h0, m_mask2});
    reg_rd(PIC_OFS_IRQ_STATUS, {29'h0, m_stat});
    reg_rd(PIC_OFS_IRQ_MASK, {29'h0, m_imask});
  endtask : read_all
  task automatic pin_step(input logic [PIC_PINS_W-1:0] nv);
    logic [PIC_PINS_W-1:0] e, f;
    f = {{5{m_ctl[2]}}, {8{m_ctl[1]}}, {8{m_ctl[0]}}};
    e = (m_lvl ^ nv) & ((f & m_lvl) | (~f & nv));
    m_f0 |= e[7:0]; m_f1 |= e[15:8]; m_f2 |= e[20:16];
    m_stat |= {|e[20:16] & m_ctl[5], |(e[15:8] & m_mask2), |(e[7:0] & {{4{m_ctl[4]}}, {4{m_ctl[3]}}})};
    m_lvl = nv;
    @(posedge mclk) want <= nv;
    repeat (8) @(posedge mclk);
    check_outs();
  endtask : pin_step

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values, every edge-select combination with random enables and pins, refusals.
  initial begin
    void'($urandom(85156));
    repeat (12) @(posedge mclk);
    reset_n <= 1;
    repeat (4) @(posedge mclk);
    read_all();
    for (int i = 0; i < 16; i++) begin
      reg_wr(PIC_OFS_CONTROL, ($urandom & 32'hff) & ~32'h7 | (i % 8));
      reg_wr(PIC_OFS_SECOND_MASK, $urandom);
      reg_wr(PIC_OFS_IRQ_MASK, $urandom);
      repeat (3) pin_step(PIC_PINS_W'($urandom));
      read_all();
      reg_wr(PIC_OFS_FIRST_FLAGS, $urandom);
      reg_wr(PIC_OFS_SECOND_FLAGS, $urandom);
      reg_wr(PIC_OFS_THIRD_FLAGS, $urandom);
      reg_wr(PIC_OFS_IRQ_STATUS, $urandom);
    end
    axi_wr(8'h9c, 32'hffffffff, resp);
    check("unmapped bresp", {30'h0, PIC_RESP_SLVERR}, {30'h0, resp});
    axi_rd(8'h40, rd, resp);
    check("unmapped rresp", {30'h0, PIC_RESP_SLVERR}, {30'h0, resp});
    check("unmapped rdata", 32'h0, rd);
    read_all();
    print_verdict();
  end

  // Cuts off a hang well past the roughly 1300 cycles the run needs.
  initial begin
    repeat (40000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end
endmodule : pic_port_irq_ctrl_tb
